/* File: verilog/pci_clock_stop_map.svh */
// Constants for the PCI clock stop control block
`ifndef PCI_CLOCK_STOP_MAP_SVH
`define PCI_CLOCK_STOP_MAP_SVH

// ----------------------------------------------------------------------------
// Output counts
// ----------------------------------------------------------------------------
`define PCS_NUM_PCI         6
`define PCS_NUM_FREE        3

// ----------------------------------------------------------------------------
// Configuration byte holding the stop-control bit
// ----------------------------------------------------------------------------
`define PCS_CFG_BYTE        8'h00
`define PCS_CFG_STOP_BIT    3
`define PCS_CFG_RESET       8'h08

// ----------------------------------------------------------------------------
// PCI phase generator: half period in clk_sys cycles, minus one
// ----------------------------------------------------------------------------
`define PCS_HALF_LAST       3'h3
`define PCS_HALF_W          3

// ----------------------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------------------
`define PCS_PIN_RESET       1'b1

`endif

/* File: verilog/pci_clock_stop_pkg.sv */
// Types for the PCI clock stop control block
package pci_clock_stop_pkg;

    // Gate state of the stoppable outputs, changed only while they are low
    typedef enum logic [0:0] {
        GATE_RUN  = 1'b0,
        GATE_STOP = 1'b1
    } gate_state_t;

    // Phase of the internal PCI clock
    typedef enum logic [0:0] {
        PHASE_LOW  = 1'b0,
        PHASE_HIGH = 1'b1
    } phase_t;

endpackage

/* File: verilog/pci_clock_stop_control.sv */
// Glitch-free stop and restart of the PCI-domain clock outputs
`timescale 1ns/100ps
`include "pci_clock_stop_map.svh"

module pci_clock_stop_control (
    input  wire logic                       clk_sys,              // 250 MHz core clock
    input  wire logic                       resetn,               // Async reset, active low
    input  wire logic                       clk_en,               // Freezes all state when low
    input  wire logic                       pci_stop_request_n,   // Stop pin, active low, async
    input  wire logic                       cfg_stop_bit,         // Config stop-control bit, 0=stop
    input  wire logic [`PCS_NUM_FREE-1:0]   cfg_free_run,         // Free-run select per output
    output logic      [`PCS_NUM_PCI-1:0]    pci_clk_out,          // Stoppable PCI clocks
    output logic      [`PCS_NUM_FREE-1:0]   free_runnable_pci_clock, // Free-runnable PCI clocks
    output logic                            pci_ref_clk_out,      // Ungated PCI-rate clock
    output logic                            stop_bit_readback,    // Combined stop-bit readback
    output logic                            pci_stopped           // Stoppable clocks are held
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic                           pin_meta_ff;
    logic                           pin_sync2_ff;
    logic                           pin_sync3_ff;
    logic                           pin_level_ff;
    logic                           nxt_pin_level;

    logic [`PCS_HALF_W-1:0]         half_cnt_ff;
    logic [`PCS_HALF_W-1:0]         nxt_half_cnt;
    logic                           half_end;
    pci_clock_stop_pkg::phase_t     phase_ff;
    pci_clock_stop_pkg::phase_t     nxt_phase;
    logic                           rise_now;
    logic                           fall_now;

    logic                           run_request;
    pci_clock_stop_pkg::gate_state_t gate_ff;
    pci_clock_stop_pkg::gate_state_t nxt_gate;

    logic [`PCS_NUM_PCI-1:0]        pci_clk_ff;
    logic [`PCS_NUM_PCI-1:0]        nxt_pci_clk;
    logic [`PCS_NUM_FREE-1:0]       free_clk_ff;
    logic [`PCS_NUM_FREE-1:0]       nxt_free_clk;
    logic [`PCS_NUM_FREE-1:0]       free_sel_ff;
    logic                           ref_clk_ff;
    logic                           readback_ff;
    logic                           stopped_ff;

    // ------------------------------------------------------------------------
    // Stop pin synchroniser
    // ------------------------------------------------------------------------
    // The first stage feeds only the second; a level change is accepted once
    // the second and third stages agree, so a single metastable sample is
    // never taken as a request.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_meta_ff  <= `PCS_PIN_RESET;
            pin_sync2_ff <= `PCS_PIN_RESET;
            pin_sync3_ff <= `PCS_PIN_RESET;
        end else if (clk_en) begin
            pin_meta_ff  <= pci_stop_request_n;
            pin_sync2_ff <= pin_meta_ff;
            pin_sync3_ff <= pin_sync2_ff;
        end
    end

    always_comb begin
        nxt_pin_level = pin_level_ff;
        if (pin_sync2_ff == pin_sync3_ff) begin
            nxt_pin_level = pin_sync3_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_level_ff <= `PCS_PIN_RESET;
        end else if (clk_en) begin
            pin_level_ff <= nxt_pin_level;
        end
    end

    // ------------------------------------------------------------------------
    // PCI phase generator
    // ------------------------------------------------------------------------
    assign half_end = (half_cnt_ff == `PCS_HALF_LAST);
    assign rise_now = half_end && (phase_ff == pci_clock_stop_pkg::PHASE_LOW);
    assign fall_now = half_end && (phase_ff == pci_clock_stop_pkg::PHASE_HIGH);

    always_comb begin
        nxt_half_cnt = half_cnt_ff + `PCS_HALF_W'(1);
        nxt_phase    = phase_ff;
        if (half_end) begin
            nxt_half_cnt = '0;
            nxt_phase    = (phase_ff == pci_clock_stop_pkg::PHASE_LOW) ?
                           pci_clock_stop_pkg::PHASE_HIGH : pci_clock_stop_pkg::PHASE_LOW;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            half_cnt_ff <= '0;
            phase_ff    <= pci_clock_stop_pkg::PHASE_LOW;
        end else if (clk_en) begin
            half_cnt_ff <= nxt_half_cnt;
            phase_ff    <= nxt_phase;
        end
    end

    // ------------------------------------------------------------------------
    // Run condition and gate
    // ------------------------------------------------------------------------
    // Pin and config bit are ANDed; a low on either stops the clocks.
    assign run_request = pin_level_ff & cfg_stop_bit;

    // The gate only moves at a falling edge, so a high phase is never cut
    // short and a restart always begins with a whole high phase. The cost is
    // up to one PCI period of extra latency on stop and on restart.
    always_comb begin
        nxt_gate = gate_ff;
        if (fall_now) begin
            nxt_gate = run_request ? pci_clock_stop_pkg::GATE_RUN :
                                     pci_clock_stop_pkg::GATE_STOP;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gate_ff <= pci_clock_stop_pkg::GATE_RUN;
        end else if (clk_en) begin
            gate_ff <= nxt_gate;
        end
    end

    // Free-run selects are sampled with the gate so an output never changes
    // mode in the middle of a high phase.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            free_sel_ff <= '0;
        end else if (clk_en && fall_now) begin
            free_sel_ff <= cfg_free_run;
        end
    end

    // ------------------------------------------------------------------------
    // Output clocks
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_pci_clk  = pci_clk_ff;
        nxt_free_clk = free_clk_ff;
        if (rise_now) begin
            if (gate_ff == pci_clock_stop_pkg::GATE_RUN) begin
                nxt_pci_clk  = '1;
                nxt_free_clk = '1;
            end else begin
                nxt_pci_clk  = '0;
                nxt_free_clk = free_sel_ff;
            end
        end else if (fall_now) begin
            nxt_pci_clk  = '0;
            nxt_free_clk = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pci_clk_ff  <= '0;
            free_clk_ff <= '0;
        end else if (clk_en) begin
            pci_clk_ff  <= nxt_pci_clk;
            free_clk_ff <= nxt_free_clk;
        end
    end

    // The reference copy never stops; it stands for the rest of the generator.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_clk_ff <= 1'b0;
        end else if (clk_en) begin
            if (rise_now) begin
                ref_clk_ff <= 1'b1;
            end else if (fall_now) begin
                ref_clk_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readback_ff <= 1'b1;
        end else if (clk_en) begin
            readback_ff <= run_request;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stopped_ff <= 1'b0;
        end else if (clk_en) begin
            stopped_ff <= (nxt_gate == pci_clock_stop_pkg::GATE_STOP);
        end
    end

    assign pci_clk_out             = pci_clk_ff;
    assign free_runnable_pci_clock = free_clk_ff;
    assign pci_ref_clk_out         = ref_clk_ff;
    assign stop_bit_readback       = readback_ff;
    assign pci_stopped             = stopped_ff;

endmodule

/* File: sim/pci_clock_stop_sva.sv */
// Assertion checker for the PCI clock stop control block
`timescale 1ns/100ps
`include "pci_clock_stop_map.svh"

module pci_clock_stop_sva (
    input wire logic                     clk_sys,                 // Core clock
    input wire logic                     resetn,                  // Async reset
    input wire logic                     clk_en,                  // Clock enable
    input wire logic                     pci_stop_request_n,      // Stop pin
    input wire logic                     cfg_stop_bit,            // Config stop bit
    input wire logic [`PCS_NUM_FREE-1:0] cfg_free_run,            // Free-run selects
    input wire logic [`PCS_NUM_PCI-1:0]  pci_clk_out,             // Stoppable clocks
    input wire logic [`PCS_NUM_FREE-1:0] free_runnable_pci_clock, // Free-runnable clocks
    input wire logic                     pci_ref_clk_out,         // Ungated clock
    input wire logic                     stop_bit_readback,       // Readback
    input wire logic                     pci_stopped              // Held flag
);
    logic [4:0] run_cnt_ff;
    logic       seen_high_ff;
    logic [3:0] fr_on_cnt_ff;
    logic [3:0] fr_off_cnt_ff;

    // Cycles since the run condition came back, saturating at two PCI periods
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) run_cnt_ff <= 5'h00;
        else if (!(pci_stop_request_n && cfg_stop_bit)) run_cnt_ff <= 5'h00;
        else if (clk_en && run_cnt_ff != 5'h10) run_cnt_ff <= run_cnt_ff + 5'h01;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) seen_high_ff <= 1'b0;
        else if (!(pci_stop_request_n && cfg_stop_bit)) seen_high_ff <= 1'b0;
        else if (pci_clk_out[0]) seen_high_ff <= 1'b1;
    end

    // Enabled cycles with free-run select 0 held high or low, saturating at eight;
    // a counter keeps the long hold out of a repetition the tools must unroll
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) fr_on_cnt_ff <= 4'h0;
        else if (!cfg_free_run[0]) fr_on_cnt_ff <= 4'h0;
        else if (clk_en && fr_on_cnt_ff != 4'h8) fr_on_cnt_ff <= fr_on_cnt_ff + 4'h1;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) fr_off_cnt_ff <= 4'h0;
        else if (cfg_free_run[0]) fr_off_cnt_ff <= 4'h0;
        else if (clk_en && fr_off_cnt_ff != 4'h8) fr_off_cnt_ff <= fr_off_cnt_ff + 4'h1;
    end

    // A low clock enable freezes the block, so phase lengths are not judged then
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn || !clk_en);

    a_stopped_held_low: assert property (pci_stopped |-> pci_clk_out == '0)
        else $error("stopped clocks not low");
    a_high_phase_full: assert property ($rose(pci_clk_out[0]) |-> pci_clk_out[0] [*4] ##1 !pci_clk_out[0])
        else $error("pci high phase wrong length");
    a_low_phase_full: assert property ($fell(pci_clk_out[0]) |-> !pci_clk_out[0] [*4])
        else $error("pci low phase shortened");
    a_ref_keeps_running: assert property ($rose(pci_ref_clk_out) |-> pci_ref_clk_out [*4] ##1 !pci_ref_clk_out [*4] ##1 pci_ref_clk_out)
        else $error("reference clock not toggling");
    a_readback_cfg_low: assert property (!cfg_stop_bit |=> !stop_bit_readback)
        else $error("readback high with config bit low");
    a_readback_pin_low: assert property (!pci_stop_request_n [*6] |-> !stop_bit_readback)
        else $error("readback high with pin low");
    a_stop_latency: assert property (!stop_bit_readback [*8] |-> ##[0:4] pci_stopped)
        else $error("stop not taken in time");
    a_restart_bound: assert property (run_cnt_ff == 5'h10 |-> seen_high_ff || pci_clk_out[0])
        else $error("no restart within two periods");
    a_free_run_kept: assert property (cfg_free_run[0] && fr_on_cnt_ff == 4'h8
        |-> free_runnable_pci_clock[0] == pci_ref_clk_out)
        else $error("free-run output not following reference");
    a_free_run_stops: assert property (!cfg_free_run[0] && fr_off_cnt_ff == 4'h8
        |-> free_runnable_pci_clock[0] == pci_clk_out[0])
        else $error("stoppable free-runnable output not gated");
endmodule

bind pci_clock_stop_control pci_clock_stop_sva chk (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .pci_stop_request_n(pci_stop_request_n), .cfg_stop_bit(cfg_stop_bit),
    .cfg_free_run(cfg_free_run), .pci_clk_out(pci_clk_out),
    .free_runnable_pci_clock(free_runnable_pci_clock), .pci_ref_clk_out(pci_ref_clk_out),
    .stop_bit_readback(stop_bit_readback), .pci_stopped(pci_stopped)
);

/* File: sim/pci_stop_pm_model.sv */
// Power-management partner that drives the stop pin
`timescale 1ns/100ps

module pci_stop_pm_model (
    input  wire logic clk_sys,            // Core clock
    input  wire logic resetn,             // Async reset
    input  wire logic want_stop,          // Bench asks for a stop
    input  wire logic slow,               // Answer four cycles late
    output logic      pci_stop_request_n  // Stop pin, active low
);
    logic [3:0] dly_ff;

    // Pin moves only on clock edges, like the chipset logic it stands for
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dly_ff             <= 4'h0;
            pci_stop_request_n <= 1'b1;
        end else begin
            dly_ff             <= {dly_ff[2:0], want_stop};
            pci_stop_request_n <= !(slow ? dly_ff[3] : want_stop);
        end
    end
endmodule

/* File: sim/tb_pci_clock_stop_control.sv */
// Self-checking bench for the PCI clock stop control block
`timescale 1ns/100ps
`include "pci_clock_stop_map.svh"

module tb_pci_clock_stop_control;
    logic                     clk_sys, resetn, clk_en, want_stop, slow, cfg_stop_bit, pin_n;
    logic [`PCS_NUM_FREE-1:0] cfg_free_run, free_clk;
    logic [`PCS_NUM_PCI-1:0]  pci_clk;
    logic                     ref_clk, readback, stopped, p_pci, p_ref, run;
    logic [`PCS_NUM_FREE-1:0] p_fr;
    logic [31:0]              rng;
    logic [11:0]              frozen;
    int                       err_total, total_checks, n_pci, n_ref;
    int                       n_fr[`PCS_NUM_FREE];

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    pci_stop_pm_model pm (.clk_sys(clk_sys), .resetn(resetn), .want_stop(want_stop),
        .slow(slow), .pci_stop_request_n(pin_n));

    pci_clock_stop_control uut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .pci_stop_request_n(pin_n), .cfg_stop_bit(cfg_stop_bit), .cfg_free_run(cfg_free_run),
        .pci_clk_out(pci_clk), .free_runnable_pci_clock(free_clk), .pci_ref_clk_out(ref_clk),
        .stop_bit_readback(readback), .pci_stopped(stopped));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Run condition is pin AND config bit, both high to run
    function automatic logic exp_run(input logic stop_req, input logic cfg);
        return !stop_req && cfg;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic results;
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Rising edges of pci_clk[0], ref_clk and each free_clk bit over two PCI periods
    task automatic count16;
        n_pci = 0;
        n_ref = 0;
        n_fr  = '{default: 0};
        {p_pci, p_ref, p_fr} = {pci_clk[0], ref_clk, free_clk};
        repeat (16) begin
            step(1);
            if (pci_clk[0] && !p_pci) n_pci++;
            if (ref_clk && !p_ref) n_ref++;
            for (int k = 0; k < `PCS_NUM_FREE; k++) if (free_clk[k] && !p_fr[k]) n_fr[k]++;
            {p_pci, p_ref, p_fr} = {pci_clk[0], ref_clk, free_clk};
        end
    endtask

    initial begin
        #80000;
        err_total++;
        results();
    end

    initial begin
        {resetn, want_stop, slow, cfg_free_run} = '0;
        {clk_en, cfg_stop_bit} = 2'b11;
        rng = 32'hd8b150e1;
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        step(20);
        // A one-cycle pin pulse is too short to be accepted
        want_stop = 1'b1;
        step(1);
        want_stop = 1'b0;
        step(20);
        check("glitch_stopped", stopped, 1'b0);
        // Clock enable low freezes every output, so no pulse is cut
        clk_en = 1'b0;
        frozen = {pci_clk, free_clk, ref_clk, readback, stopped};
        step(11);
        check("frozen", {pci_clk, free_clk, ref_clk, readback, stopped}, frozen);
        clk_en = 1'b1;
        step(2);
        for (int i = 0; i < 48; i++) begin
            rng = xs(rng);
            want_stop = rng[0];
            step(int'(rng[10:8]) + 1);
            rng = xs(rng);
            // Corner cases first: every pin and config pairing
            {want_stop, cfg_stop_bit} = (i < 4) ? i[1:0] : {rng[0], rng[1]};
            cfg_free_run = rng[4:2];
            slow = rng[5];
            step(24);
            run = exp_run(want_stop, cfg_stop_bit);
            check("readback", readback, run);
            check("stopped", stopped, !run);
            count16();
            check("pci_rises", n_pci, run ? 2 : 0);
            check("pci_level", pci_clk, run ? {`PCS_NUM_PCI{ref_clk}} : '0);
            check("ref_rises", n_ref, 2);
            for (int k = 0; k < `PCS_NUM_FREE; k++)
                check("free_rises", n_fr[k], (cfg_free_run[k] || run) ? 2 : 0);
        end
        results();
    end
endmodule
